// *** hw/fpsc_setup_regs.sv ***
// Floppy output setup, DMA strobing, density override and serial clock select
`timescale 1ns/100ps
module fpsc_setup_regs (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cfg_mode,
  input wire logic [7:0] config_index,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic core_motor,
  input wire logic core_density_select,
  input wire logic core_drive_density_one,
  input wire logic density_one_force_bit,
  input wire logic pp_floppy_sel,
  input wire logic fifo_en,
  input wire logic core_dma_req,
  input wire logic core_irq,
  input wire logic byte_done,
  input wire logic [2:0] ecr_mode,
  input wire logic ref_tick,
  output logic floppy_drive_motor_o,
  output logic floppy_drive_motor_oe,
  output logic floppy_drive_density_select_o,
  output logic floppy_drive_density_select_oe,
  output logic drive_density_out_one_o,
  output logic drive_density_out_one_oe,
  output logic pp_motor_o,
  output logic pp_motor_oe,
  output logic floppy_dma_request,
  output logic floppy_interrupt_request,
  output logic [1:0] pp_active_mode,
  output logic uart1_clk_tick,
  output logic uart2_clk_tick
);
  logic [7:0] floppy_setup_r;
  logic [7:0] port_extended_setup_r;
  logic setup_sel;
  logic ext_sel;
  logic push_pull;
  logic tri_out;
  logic [1:0] density_select_override;
  logic density_sel_val;
  logic dd1_val;
  fpsc_pkg::fpsc_dma_state_t dma_state_r;
  fpsc_pkg::fpsc_dma_state_t dma_state_nxt;
  logic [3:0] pre16_r;
  logic tick16;
  logic [1:0] pp_mode_nxt;

  assign setup_sel = cfg_mode && (config_index == fpsc_pkg::FLOPPY_SETUP_IDX);
  assign ext_sel = cfg_mode && (config_index == fpsc_pkg::PORT_EXT_SETUP_IDX);
  assign push_pull = floppy_setup_r[fpsc_pkg::OUT_TYPE_BIT];
  assign tri_out = floppy_setup_r[fpsc_pkg::OUT_TRI_BIT];
  assign density_select_override = floppy_setup_r[fpsc_pkg::DEN_OVR_HI_BIT:fpsc_pkg::DEN_OVR_LO_BIT];

  // Register writes
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      floppy_setup_r <= fpsc_pkg::FLOPPY_SETUP_RST;
      port_extended_setup_r <= fpsc_pkg::PORT_EXT_SETUP_RST;
    end
    else if (cfg_wr)
    begin
      if (setup_sel)
        floppy_setup_r <= cfg_wdata & fpsc_pkg::FLOPPY_SETUP_WMASK;
      if (ext_sel)
        port_extended_setup_r <= cfg_wdata & fpsc_pkg::PORT_EXT_SETUP_WMASK;
    end
  end

  // Register reads, one cycle latency; unselected index reads zero
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
    end
    else
    begin
      cfg_rvalid <= cfg_rd && (setup_sel || ext_sel);
      if (cfg_rd && setup_sel)
        cfg_rdata <= floppy_setup_r;
      else if (cfg_rd && ext_sel)
        cfg_rdata <= port_extended_setup_r;
      else
        cfg_rdata <= 8'h00;
    end
  end

  always_comb
  begin
    density_sel_val = core_density_select;
    unique case (density_select_override)
      fpsc_pkg::DEN_OVR_FORCE_ONE: density_sel_val = 1'b1;
      fpsc_pkg::DEN_OVR_FORCE_ZERO: density_sel_val = 1'b0;
      default: density_sel_val = core_density_select;
    endcase
    dd1_val = density_one_force_bit ? 1'b1 : core_drive_density_one;
  end

  // Open drain drives only lows; push-pull drives both levels
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      floppy_drive_motor_o <= 1'b0;
      floppy_drive_motor_oe <= 1'b0;
      floppy_drive_density_select_o <= 1'b0;
      floppy_drive_density_select_oe <= 1'b0;
      drive_density_out_one_o <= 1'b0;
      drive_density_out_one_oe <= 1'b0;
    end
    else
    begin
      floppy_drive_motor_o <= core_motor;
      floppy_drive_motor_oe <= !tri_out && (push_pull || !core_motor);
      floppy_drive_density_select_o <= density_sel_val;
      floppy_drive_density_select_oe <= !tri_out && (push_pull || !density_sel_val);
      drive_density_out_one_o <= dd1_val;
      drive_density_out_one_oe <= !tri_out && (push_pull || !dd1_val);
    end
  end

  // Parallel-port floppy path is always push-pull; tri-stated only while pp_floppy_sel is low
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pp_motor_o <= 1'b0;
      pp_motor_oe <= 1'b0;
    end
    else
    begin
      pp_motor_o <= core_motor;
      pp_motor_oe <= pp_floppy_sel;
    end
  end

  // Non-burst strobing, with the FIFO enabled only: a low gap after each byte separates the strobes
  always_comb
  begin
    dma_state_nxt = dma_state_r;
    unique case (dma_state_r)
      fpsc_pkg::FPSC_DMA_IDLE:
        if (core_dma_req)
          dma_state_nxt = fpsc_pkg::FPSC_DMA_ASSERT;
      fpsc_pkg::FPSC_DMA_ASSERT:
        if (!core_dma_req)
          dma_state_nxt = fpsc_pkg::FPSC_DMA_IDLE;
        else if (byte_done)
          dma_state_nxt = fpsc_pkg::FPSC_DMA_GAP;
      fpsc_pkg::FPSC_DMA_GAP:
        dma_state_nxt = core_dma_req ? fpsc_pkg::FPSC_DMA_ASSERT : fpsc_pkg::FPSC_DMA_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      dma_state_r <= fpsc_pkg::FPSC_DMA_IDLE;
    else
      dma_state_r <= dma_state_nxt;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      floppy_dma_request <= 1'b0;
      floppy_interrupt_request <= 1'b0;
    end
    else if (floppy_setup_r[fpsc_pkg::DMA_MODE_BIT] && fifo_en)
    begin
      floppy_dma_request <= (dma_state_nxt == fpsc_pkg::FPSC_DMA_ASSERT);
      floppy_interrupt_request <= core_irq && (dma_state_nxt != fpsc_pkg::FPSC_DMA_GAP);
    end
    else
    begin
      floppy_dma_request <= core_dma_req;
      floppy_interrupt_request <= core_irq;
    end
  end

  // ECR may step the configured mode down to EPP or SPP
  always_comb
  begin
    pp_mode_nxt = port_extended_setup_r[1:0];
    if (port_extended_setup_r[1:0] == fpsc_pkg::PP_MODE_ECP_EPP && ecr_mode == fpsc_pkg::ECR_MODE_EPP)
      pp_mode_nxt = fpsc_pkg::PP_MODE_EPP;
    else if (port_extended_setup_r[1] && ecr_mode == fpsc_pkg::ECR_MODE_SPP)
      pp_mode_nxt = fpsc_pkg::PP_MODE_SPP;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      pp_active_mode <= fpsc_pkg::PP_MODE_SPP;
    else
      pp_active_mode <= pp_mode_nxt;
  end

  // ref_tick is the 24 MHz reference as a same-clock enable; /16 shared
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      pre16_r <= 4'h0;
    else if (ref_tick)
      pre16_r <= pre16_r + 4'h1;
  end

  assign tick16 = ref_tick && (pre16_r == 4'(fpsc_pkg::BAUD_OVERSAMPLE - 1));

  fpsc_baud_div #(.CNT_W(4)) u_div1 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ref_tick(tick16),
    .midi_en(port_extended_setup_r[fpsc_pkg::MIDI1_BIT]),
    .div_tick(uart1_clk_tick)
  );

  fpsc_baud_div #(.CNT_W(4)) u_div2 (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ref_tick(tick16),
    .midi_en(port_extended_setup_r[fpsc_pkg::MIDI2_BIT]),
    .div_tick(uart2_clk_tick)
  );

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    floppy_setup_r[7:5] == 3'h0) else $error("reserved setup bits set");
  a_write_gated: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_wr && !setup_sel |=> $stable(floppy_setup_r)) else $error("setup changed without select");
  a_tri_all: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(tri_out) |-> !floppy_drive_motor_oe && !floppy_drive_density_select_oe && !drive_density_out_one_oe)
    else $error("floppy output driven while tri-stated");
  a_force_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !tri_out && density_one_force_bit |=> drive_density_out_one_o) else $error("density one not forced");
  a_dd1_normal: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !density_one_force_bit |=> drive_density_out_one_o == $past(core_drive_density_one))
    else $error("density one not passed");
  a_tri_beats_force: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tri_out && density_one_force_bit |=> !drive_density_out_one_oe) else $error("force bit drove tristate");
  a_open_drain_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !push_pull && !tri_out |=> (floppy_drive_motor_oe == !floppy_drive_motor_o))
    else $error("open drain drove high");
  a_push_pull_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
    push_pull && !tri_out |=> floppy_drive_motor_oe && floppy_drive_density_select_oe && drive_density_out_one_oe)
    else $error("push-pull output not driven");
  a_burst_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !floppy_setup_r[fpsc_pkg::DMA_MODE_BIT] |=> floppy_dma_request == $past(core_dma_req))
    else $error("burst request not passed");
  a_fifo_off_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !fifo_en |=> floppy_dma_request == $past(core_dma_req)) else $error("request strobed with fifo off");
  a_nonburst_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    floppy_setup_r[fpsc_pkg::DMA_MODE_BIT] && fifo_en && dma_state_r == fpsc_pkg::FPSC_DMA_ASSERT
    && byte_done && core_dma_req |=> !floppy_dma_request && !floppy_interrupt_request)
    else $error("no strobe gap per byte");
  a_pp_untouched: assert property (@(posedge sys_clk) disable iff (!rst_n)
    pp_floppy_sel |=> pp_motor_oe && pp_motor_o == $past(core_motor)) else $error("pp floppy path disturbed");
  a_den_force_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    density_select_override == fpsc_pkg::DEN_OVR_FORCE_ZERO |=> !floppy_drive_density_select_o)
    else $error("density select not forced low");
  a_den_force_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
    density_select_override == fpsc_pkg::DEN_OVR_FORCE_ONE |=> floppy_drive_density_select_o)
    else $error("density select not forced high");
  a_den_normal: assert property (@(posedge sys_clk) disable iff (!rst_n)
    density_select_override == fpsc_pkg::DEN_OVR_NORMAL
    |=> floppy_drive_density_select_o == $past(core_density_select)) else $error("density select not passed");
  a_epp_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    port_extended_setup_r[1:0] == fpsc_pkg::PP_MODE_ECP_EPP && ecr_mode == fpsc_pkg::ECR_MODE_EPP
    |=> pp_active_mode == fpsc_pkg::PP_MODE_EPP) else $error("ecr epp not taken");
  a_spp_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    port_extended_setup_r[1] && ecr_mode == fpsc_pkg::ECR_MODE_SPP |=> pp_active_mode == fpsc_pkg::PP_MODE_SPP)
    else $error("ecr spp not taken");
  a_mode_plain: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ecr_mode != fpsc_pkg::ECR_MODE_EPP && ecr_mode != fpsc_pkg::ECR_MODE_SPP
    |=> pp_active_mode == $past(port_extended_setup_r[1:0])) else $error("parallel mode not kept");
  a_reset_value: assert property (@(posedge sys_clk)
    !rst_n |=> floppy_setup_r == fpsc_pkg::FLOPPY_SETUP_RST) else $error("setup reset wrong");
  a_midi_tick: assert property (@(posedge sys_clk) disable iff (!rst_n)
    uart1_clk_tick |-> !$past(uart1_clk_tick)) else $error("uart tick too long");

  c_write_setup: cover property (@(posedge sys_clk) disable iff (!rst_n) cfg_wr && setup_sel);
  c_nonburst_gap: cover property (@(posedge sys_clk) disable iff (!rst_n) dma_state_r == fpsc_pkg::FPSC_DMA_GAP);
  c_tristate: cover property (@(posedge sys_clk) disable iff (!rst_n) tri_out && density_one_force_bit);
  c_midi_tick: cover property (@(posedge sys_clk) disable iff (!rst_n)
    uart1_clk_tick && port_extended_setup_r[fpsc_pkg::MIDI1_BIT]);
  c_epp_mode: cover property (@(posedge sys_clk) disable iff (!rst_n) pp_active_mode == fpsc_pkg::PP_MODE_EPP);
endmodule : fpsc_setup_regs

// *** include/fpsc_pkg.sv ***
// Constants and types for the floppy port setup configuration block
package fpsc_pkg;
  localparam logic [7:0] FLOPPY_SETUP_IDX = 8'h05;
  localparam logic [7:0] PORT_EXT_SETUP_IDX = 8'h04;
  localparam logic [7:0] FLOPPY_SETUP_RST = 8'h00;
  localparam logic [7:0] PORT_EXT_SETUP_RST = 8'h00;
  localparam int OUT_TYPE_BIT = 0;
  localparam int OUT_TRI_BIT = 1;
  localparam int DMA_MODE_BIT = 2;
  localparam int DEN_OVR_LO_BIT = 3;
  localparam int DEN_OVR_HI_BIT = 4;
  localparam logic [7:0] FLOPPY_SETUP_WMASK = 8'h1f;
  localparam int MIDI1_BIT = 4;
  localparam int MIDI2_BIT = 5;
  localparam logic [7:0] PORT_EXT_SETUP_WMASK = 8'h7f;
  localparam logic [2:0] ECR_MODE_SPP = 3'h0;
  localparam logic [2:0] ECR_MODE_EPP = 3'h4;
  localparam logic [1:0] PP_MODE_SPP = 2'h0;
  localparam logic [1:0] PP_MODE_EPP = 2'h1;
  localparam logic [1:0] PP_MODE_ECP = 2'h2;
  localparam logic [1:0] PP_MODE_ECP_EPP = 2'h3;
  localparam logic [1:0] DEN_OVR_NORMAL = 2'h0;
  localparam logic [1:0] DEN_OVR_FORCE_ONE = 2'h2;
  localparam logic [1:0] DEN_OVR_FORCE_ZERO = 2'h3;
  localparam int BAUD_DIV_MIDI = 12;
  localparam int BAUD_DIV_STD = 13;
  localparam int BAUD_OVERSAMPLE = 16;
  localparam int STROBE_CYCLES = 1;
  typedef enum logic [1:0] {FPSC_DMA_IDLE, FPSC_DMA_ASSERT, FPSC_DMA_GAP} fpsc_dma_state_t;
endpackage : fpsc_pkg

// *** hw/fpsc_baud_div.sv ***
// Serial reference clock divider with MIDI select
`timescale 1ns/100ps
module fpsc_baud_div #(
  parameter int CNT_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ref_tick,
  input wire logic midi_en,
  output logic div_tick
);
  localparam logic [CNT_W-1:0] LAST_MIDI = CNT_W'(fpsc_pkg::BAUD_DIV_MIDI - 1);
  localparam logic [CNT_W-1:0] LAST_STD = CNT_W'(fpsc_pkg::BAUD_DIV_STD - 1);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] last;

  assign last = midi_en ? LAST_MIDI : LAST_STD;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      div_tick <= 1'b0;
    end
    else
    begin
      div_tick <= 1'b0;
      if (ref_tick)
      begin
        // Wrap also on a select change so a shorter count never overruns
        if (cnt_r >= last)
        begin
          cnt_r <= '0;
          div_tick <= 1'b1;
        end
        else
          cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  a_div_wrap_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cnt_r <= LAST_STD) else $error("divider count out of range");
endmodule : fpsc_baud_div

// *** verification/fpsc_host_model.sv ***
// Host processor model issuing configuration register cycles
`timescale 1ns/100ps
module fpsc_host_model (
  input wire logic sys_clk,
  output logic cfg_mode,
  output logic [7:0] config_index,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [7:0] cfg_wdata
);
  initial
  begin
    cfg_mode = 1'b0;
    config_index = 8'h00;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_wdata = 8'h00;
  end

  // One strobe cycle; index and data scrambled after so nothing stale looks valid
  task automatic access(input logic mode, input logic [7:0] idx, input logic wr, input logic [7:0] d);
    @(posedge sys_clk);
    cfg_mode <= mode;
    config_index <= idx;
    cfg_wr <= wr;
    cfg_rd <= ~wr;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    config_index <= ~idx;
    cfg_wdata <= ~d;
  endtask : access
endmodule : fpsc_host_model

// *** verification/fpsc_setup_regs_test.sv ***
// Self-checking bench for the floppy setup register block
`timescale 1ns/100ps
module fpsc_setup_regs_test;
  logic sys_clk, rst_n, cfg_mode, cfg_wr, cfg_rd, cfg_rvalid;
  logic [7:0] config_index, cfg_wdata, cfg_rdata;
  logic core_motor, core_density_select, core_drive_density_one, density_one_force_bit;
  logic pp_floppy_sel, fifo_en, core_dma_req, core_irq, byte_done, ref_tick;
  logic [2:0] ecr_mode;
  logic floppy_drive_motor_o, floppy_drive_motor_oe, floppy_drive_density_select_o, floppy_drive_density_select_oe;
  logic drive_density_out_one_o, drive_density_out_one_oe, pp_motor_o, pp_motor_oe;
  logic floppy_dma_request, floppy_interrupt_request, uart1_clk_tick, uart2_clk_tick;
  logic [1:0] pp_active_mode;
  logic [7:0] exp_q [$];
  int fails = 0;
  int n_tests = 0;
  // Pin inputs {csel,force,dd1,motor}, setup value, expected pins, compare mask
  logic [31:0] pin_tab [6] = '{32'h0500_9bff, 32'h0501_dfff, 32'h0101_d7ff,
                               32'h0503_0357, 32'h0510_abff, 32'h0d18_9bff};

  fpsc_host_model u_host (.sys_clk(sys_clk), .cfg_mode(cfg_mode), .config_index(config_index),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata));

  fpsc_setup_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_mode(cfg_mode),
    .config_index(config_index), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .core_motor(core_motor),
    .core_density_select(core_density_select), .core_drive_density_one(core_drive_density_one),
    .density_one_force_bit(density_one_force_bit), .pp_floppy_sel(pp_floppy_sel), .fifo_en(fifo_en),
    .core_dma_req(core_dma_req), .core_irq(core_irq), .byte_done(byte_done), .ecr_mode(ecr_mode),
    .ref_tick(ref_tick), .floppy_drive_motor_o(floppy_drive_motor_o), .floppy_drive_motor_oe(floppy_drive_motor_oe),
    .floppy_drive_density_select_o(floppy_drive_density_select_o),
    .floppy_drive_density_select_oe(floppy_drive_density_select_oe),
    .drive_density_out_one_o(drive_density_out_one_o), .drive_density_out_one_oe(drive_density_out_one_oe),
    .pp_motor_o(pp_motor_o), .pp_motor_oe(pp_motor_oe), .floppy_dma_request(floppy_dma_request),
    .floppy_interrupt_request(floppy_interrupt_request), .pp_active_mode(pp_active_mode),
    .uart1_clk_tick(uart1_clk_tick), .uart2_clk_tick(uart2_clk_tick));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Read data is judged by the monitor, oldest note first
  always @(negedge sys_clk)
  begin
    if (cfg_rvalid === 1'b1)
    begin
      n_tests++;
      if (exp_q.size() == 0 || cfg_rdata !== exp_q[0])
      begin
        fails++;
        $display("mismatch at %0t: read data %h", $time, cfg_rdata);
      end
      if (exp_q.size() != 0)
        exp_q.delete(0);
    end
  end

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    u_host.access(1'b1, idx, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    exp_q.push_back(exp);
    u_host.access(1'b1, idx, 1'b0, 8'h00);
  endtask : rd

  // Outputs lag the register by one edge
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle

  task automatic ecr_chk(input logic [2:0] e, input logic [1:0] want);
    @(posedge sys_clk);
    ecr_mode <= e;
    settle();
    chk({6'h00, pp_active_mode}, {6'h00, want});
  endtask : ecr_chk

  task automatic period(input logic sel, output logic [7:0] n);
    int c;
    c = 0;
    @(negedge sys_clk);
    while ((sel ? uart2_clk_tick : uart1_clk_tick) !== 1'b1 && c < 600)
    begin
      @(negedge sys_clk);
      c++;
    end
    c = 0;
    do
    begin
      @(negedge sys_clk);
      c++;
    end
    while ((sel ? uart2_clk_tick : uart1_clk_tick) !== 1'b1 && c < 600);
    n = 8'(c);
  endtask : period

  initial
  begin
    #400000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end

  initial
  begin
    logic [7:0] d, dl, il;
    rst_n = 1'b0;
    {core_density_select, density_one_force_bit, core_drive_density_one, core_motor} = 4'h0;
    {pp_floppy_sel, fifo_en, core_dma_req, core_irq, ref_tick} = 5'h1f;
    byte_done = 1'b0;
    ecr_mode = 3'h0;
    void'($urandom(32'ha847ff6b));
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h05, 8'h00);
    wr(8'h05, 8'hff);
    rd(8'h05, 8'h1f);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom());
      wr(8'h05, d);
      rd(8'h05, d & 8'h1f);
    end
    u_host.access(1'b0, 8'h05, 1'b1, ~d);
    rd(8'h05, d & 8'h1f);
    u_host.access(1'b1, 8'h06, 1'b0, 8'h00);
    @(negedge sys_clk);
    chk({7'h00, cfg_rvalid}, 8'h00);
    chk(cfg_rdata, 8'h00);
    $display("register access test done");
    for (int i = 0; i < 6; i++)
    begin
      @(posedge sys_clk);
      {core_density_select, density_one_force_bit, core_drive_density_one, core_motor} <= pin_tab[i][27:24];
      wr(8'h05, pin_tab[i][23:16]);
      settle();
      chk({floppy_drive_motor_o, floppy_drive_motor_oe, floppy_drive_density_select_o,
        floppy_drive_density_select_oe, drive_density_out_one_o, drive_density_out_one_oe, pp_motor_o,
        pp_motor_oe} & pin_tab[i][7:0], pin_tab[i][15:8]);
    end
    $display("pin control test done");
    // Reset again mid-run: the setup register must fall back to zero
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h05, 8'h00);
    // Third pass: burst, then non-burst with FIFO on (one gap), then non-burst with FIFO off, where requests pass through
    for (int m = 0; m < 3; m++)
    begin
      @(posedge sys_clk);
      fifo_en <= (m != 2);
      wr(8'h05, (m != 0) ? 8'h04 : 8'h00);
      settle();
      @(posedge sys_clk);
      byte_done <= 1'b1;
      @(posedge sys_clk);
      byte_done <= 1'b0;
      dl = 8'h00;
      il = 8'h00;
      repeat (6)
      begin
        @(negedge sys_clk);
        dl = dl + 8'(floppy_dma_request !== 1'b1);
        il = il + 8'(floppy_interrupt_request !== 1'b1);
      end
      chk(dl, 8'(m == 1));
      chk(il, 8'(m == 1));
    end
    $display("dma strobe test done");
    wr(8'h04, 8'h03);
    ecr_chk(3'h1, 2'h3);
    ecr_chk(3'h4, 2'h1);
    ecr_chk(3'h0, 2'h0);
    wr(8'h04, 8'h10);
    period(1'b0, d);
    chk(d, 8'd192);
    period(1'b1, d);
    chk(d, 8'd208);
    $display("parallel and serial setup test done");
    stop_test();
  end
endmodule : fpsc_setup_regs_test
